// [cpar_top.sv]
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`include "cpar_map.svh"
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module cpar_top #(
   parameter logic [15:0] RESET_VECTOR = 16'h0100
) (
   // clock and reset
   input  logic        mclk,
   input  logic        srst,
   // avalon-mm slave
   input  logic [4:0]  avs_address,
   input  logic        avs_read,
   input  logic        avs_write,
   input  logic [31:0] avs_writedata,
   input  logic [3:0]  avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic        avs_waitrequest,
   // system
   input  logic        reset_n_input,
   input  logic        sub_mode,
   input  logic        irq_req,
   output logic        irq_ack,
   output logic        imask,
   output logic        cpu_halted,
   output logic [15:0] pc,
   // port 1, standard voltage
   input  logic [7:0]  port1_pin_in,
   output logic [7:0]  port1_pin_out,
   output logic [7:0]  port1_pin_oe,
   // port a, high voltage
   input  logic [7:0]  porta_pin_in,
   output logic [7:0]  porta_pin_out,
   output logic [7:0]  porta_pin_oe
);

   localparam logic [15:0] TMR_ADDR [0:2] = '{`CPAR_A_TIMER_B,
                                              `CPAR_A_TIMER_C,
                                              `CPAR_A_TIMER_E};

   cpar_pkg::cpar_state_t state_q;
   cpar_pkg::cpar_op_t    op_q;
   logic [2:0]            bit_q;
   logic                  carry_q;
   logic [15:0]           addr_q;
   logic [31:0]           cmd_q;
   logic [15:0]           data_q;
   logic [15:0]           result_q;
   logic [7:0]            byte_q;
   logic [7:0]            wr_val_q;
   logic [15:0]           pc_q;
   logic                  imask_q;
   logic                  unmapped_q;
   logic                  cmd_pend_q;
   logic                  wait_q;
   logic [31:0]           readdata_q;
   logic                  irq_ack_q;
   logic                  rst_s1_q;
   logic                  rst_s2_q;
   logic                  halted_q;
   logic [7:0]            timer_d_mode_q;
   logic [7:0]            system_control_two_q;
   logic [7:0]            tmr_cnt [0:2];
   logic [2:0]            tmr_wr;
   logic [7:0]            rd_byte;
   logic [31:0]           reg_rd;
   logic [31:0]           cmd_new;
   logic                  cmd_wr;
   logic                  reg_take;
   logic                  cmd_start;
   logic                  irq_take;
   logic                  per_wr;
   logic                  bad_acc;
   logic [31:0]           data_new;

   cpar_pbus_if p1_if ();
   cpar_pbus_if pa_if ();

   function automatic logic is_mapped(input logic [15:0] a);
      case (a)
         `CPAR_A_TIMER_B, `CPAR_A_TIMER_C, `CPAR_A_TIMER_E,
         `CPAR_A_TMODE_D, `CPAR_A_PORT1, `CPAR_A_PORTA,
         `CPAR_A_PORT1_DIR, `CPAR_A_SYSCTL2: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_rom(input logic [15:0] a);
      is_rom = (a == `CPAR_A_VEC_HI) || (a == `CPAR_A_VEC_LO);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reset pin synchroniser and halt state

   always_ff @(posedge mclk) begin
      if (srst) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= reset_n_input;
         rst_s2_q <= rst_s1_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         halted_q <= 1'b1;
      end else begin
         halted_q <= ~rst_s2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request decode

   assign cmd_wr    = avs_write && (avs_address == `CPAR_REG_CMD);
   assign reg_take  = wait_q && !cmd_pend_q && (avs_read || avs_write);
   assign irq_take  = (state_q == cpar_pkg::S_IDLE) && irq_req &&
                      !imask_q && !halted_q;
   // a command waits for the instruction boundary, never splits one
   assign cmd_start = reg_take && cmd_wr && !halted_q &&
                      (state_q == cpar_pkg::S_IDLE) && !irq_take;
   assign cmd_new   = be_merge(cmd_q, avs_writedata, avs_byteenable);
   assign data_new  = be_merge({16'h0000, data_q}, avs_writedata,
                               avs_byteenable);
   assign per_wr    = (state_q == cpar_pkg::S_WR_B) && is_mapped(addr_q);
   assign bad_acc   = ((state_q == cpar_pkg::S_RD_B) ||
                       (state_q == cpar_pkg::S_WR_B)) &&
                      !is_mapped(addr_q) && !is_rom(addr_q);

   ////////////////////////////////////////////////////////////////////////
   // avalon handshake

   always_ff @(posedge mclk) begin
      if (srst) begin
         wait_q     <= 1'b1;
         cmd_pend_q <= 1'b0;
         readdata_q <= 32'h0000_0000;
      end else begin
         wait_q <= 1'b1;
         if (cmd_pend_q) begin
            if (state_q == cpar_pkg::S_DONE || halted_q) begin
               wait_q     <= 1'b0;
               cmd_pend_q <= 1'b0;
            end
         end else if (cmd_start) begin
            cmd_pend_q <= 1'b1;
         end else if (reg_take && !(cmd_wr && !halted_q)) begin
            wait_q     <= 1'b0;
            readdata_q <= avs_read ? reg_rd : 32'h0000_0000;
         end
      end
   end

   always_comb begin
      case (avs_address)
         `CPAR_REG_CMD:    reg_rd = cmd_q;
         `CPAR_REG_DATA:   reg_rd = {16'h0000, data_q};
         `CPAR_REG_RESULT: reg_rd = {16'h0000, result_q};
         `CPAR_REG_STATUS: reg_rd = {28'h0000000, imask_q, sub_mode,
                                     unmapped_q, halted_q};
         `CPAR_REG_PC:     reg_rd = {16'h0000, pc_q};
         `CPAR_REG_CCR:    reg_rd = {31'h00000000, imask_q};
         default:          reg_rd = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         data_q <= 16'h0000;
      end else if (reg_take && avs_write &&
                   avs_address == `CPAR_REG_DATA) begin
         data_q <= data_new[15:0];
      end
   end

   // an unmapped hit wins over a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (srst) begin
         unmapped_q <= 1'b0;
      end else if (bad_acc) begin
         unmapped_q <= 1'b1;
      end else if (reg_take && avs_write &&
                   avs_address == `CPAR_REG_STATUS &&
                   avs_byteenable[0] &&
                   avs_writedata[`CPAR_ST_UNMAPPED]) begin
         unmapped_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || halted_q) begin
         imask_q <= 1'b1;
      end else if (irq_take) begin
         imask_q <= 1'b1;
      end else if (reg_take && avs_write &&
                   avs_address == `CPAR_REG_CCR && avs_byteenable[0]) begin
         imask_q <= avs_writedata[0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq_ack_q <= 1'b0;
      end else begin
         irq_ack_q <= irq_take;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command sequencer, two states per byte access

   always_ff @(posedge mclk) begin
      if (srst) begin
         cmd_q   <= 32'h0000_0000;
         op_q    <= cpar_pkg::OP_RDB;
         bit_q   <= 3'h0;
         carry_q <= 1'b0;
         addr_q  <= 16'h0000;
      end else if (cmd_start) begin
         cmd_q   <= cmd_new;
         op_q    <= cpar_pkg::cpar_op_t'(cmd_new[`CPAR_CMD_OP_LSB +: 4]);
         bit_q   <= cmd_new[`CPAR_CMD_BIT_LSB +: 3];
         carry_q <= cmd_new[`CPAR_CMD_CARRY];
         addr_q  <= cmd_new[`CPAR_CMD_ADDR_LSB +: 16];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || halted_q) begin
         state_q <= cpar_pkg::S_RESET;
      end else begin
         case (state_q)
            cpar_pkg::S_RESET: state_q <= cpar_pkg::S_VEC;
            cpar_pkg::S_VEC:   state_q <= cpar_pkg::S_FETCH;
            cpar_pkg::S_FETCH: state_q <= cpar_pkg::S_IDLE;
            cpar_pkg::S_IDLE: begin
               if (cmd_start) begin
                  case (cpar_pkg::cpar_op_t'(cmd_new[3:0]))
                     cpar_pkg::OP_WRB,
                     cpar_pkg::OP_WRW: state_q <= cpar_pkg::S_WR_A;
                     cpar_pkg::OP_RDB, cpar_pkg::OP_RDW, cpar_pkg::OP_SET,
                     cpar_pkg::OP_CLR, cpar_pkg::OP_NOT, cpar_pkg::OP_ST,
                     cpar_pkg::OP_IST: state_q <= cpar_pkg::S_RD_A;
                     default:          state_q <= cpar_pkg::S_DONE;
                  endcase
               end
            end
            cpar_pkg::S_RD_A: state_q <= cpar_pkg::S_RD_B;
            cpar_pkg::S_RD_B: begin
               if (op_q == cpar_pkg::OP_RDB || op_q == cpar_pkg::OP_RDW) begin
                  state_q <= cpar_pkg::S_DONE;
               end else begin
                  state_q <= cpar_pkg::S_MOD;
               end
            end
            cpar_pkg::S_MOD:  state_q <= cpar_pkg::S_WR_A;
            cpar_pkg::S_WR_A: state_q <= cpar_pkg::S_WR_B;
            cpar_pkg::S_WR_B: state_q <= cpar_pkg::S_DONE;
            cpar_pkg::S_DONE: state_q <= cpar_pkg::S_IDLE;
            default:          state_q <= cpar_pkg::S_RESET;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || halted_q) begin
         pc_q <= 16'h0000;
      end else if (state_q == cpar_pkg::S_FETCH) begin
         pc_q <= RESET_VECTOR;
      end
   end

   // only one byte ever travels; a word write keeps its upper byte
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_val_q <= 8'h00;
      end else if (cmd_start) begin
         if (cmd_new[3:0] == cpar_pkg::OP_WRW) begin
            wr_val_q <= data_q[15:8];
         end else begin
            wr_val_q <= data_q[7:0];
         end
      end else if (state_q == cpar_pkg::S_MOD) begin
         wr_val_q <= byte_q;
         case (op_q)
            cpar_pkg::OP_SET: wr_val_q[bit_q] <= 1'b1;
            cpar_pkg::OP_CLR: wr_val_q[bit_q] <= 1'b0;
            cpar_pkg::OP_NOT: wr_val_q[bit_q] <= ~byte_q[bit_q];
            cpar_pkg::OP_ST:  wr_val_q[bit_q] <= carry_q;
            cpar_pkg::OP_IST: wr_val_q[bit_q] <= ~carry_q;
            default:          wr_val_q[bit_q] <= byte_q[bit_q];
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         byte_q   <= 8'h00;
         result_q <= 16'h0000;
      end else if (state_q == cpar_pkg::S_RD_B) begin
         byte_q <= rd_byte;
         if (op_q == cpar_pkg::OP_RDW) begin
            if (addr_q == `CPAR_A_VEC_HI) begin
               result_q <= RESET_VECTOR;
            end else begin
               result_q <= {rd_byte, `CPAR_UNDEF_BYTE};
            end
         end else if (op_q == cpar_pkg::OP_RDB) begin
            result_q <= {8'h00, rd_byte};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // peripheral read mux

   always_comb begin
      rd_byte = `CPAR_UNDEF_BYTE;
      case (addr_q)
         `CPAR_A_TMODE_D:   rd_byte = timer_d_mode_q | `CPAR_TMODE_WO_MASK;
         `CPAR_A_SYSCTL2:   rd_byte = system_control_two_q |
                                      `CPAR_SYSCTL2_WO_MASK;
         `CPAR_A_PORT1_DIR: rd_byte = `CPAR_DIR_WO_MASK;
         `CPAR_A_PORT1:     rd_byte = p1_if.rdata;
         `CPAR_A_PORTA:     rd_byte = pa_if.rdata;
         `CPAR_A_VEC_HI:    rd_byte = RESET_VECTOR[15:8];
         `CPAR_A_VEC_LO:    rd_byte = RESET_VECTOR[7:0];
         default:           rd_byte = `CPAR_UNDEF_BYTE;
      endcase
      for (int i = 0; i < 3; i++) begin
         if (addr_q == TMR_ADDR[i]) begin
            rd_byte = tmr_cnt[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // peripheral registers

   always_ff @(posedge mclk) begin
      if (srst || halted_q) begin
         timer_d_mode_q <= `CPAR_TMODE_RST;
      end else if (per_wr && addr_q == `CPAR_A_TMODE_D) begin
         timer_d_mode_q <= wr_val_q;
      end
   end

   // in main-clock mode the transfer bit ignores writes entirely
   always_ff @(posedge mclk) begin
      if (srst || halted_q) begin
         system_control_two_q <= `CPAR_SYSCTL2_RST;
      end else if (per_wr && addr_q == `CPAR_A_SYSCTL2) begin
         system_control_two_q <= wr_val_q;
         if (!sub_mode) begin
            system_control_two_q[`CPAR_DIRECT_TRANSFER_ON_BIT] <=
               system_control_two_q[`CPAR_DIRECT_TRANSFER_ON_BIT];
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_tmr
         assign tmr_wr[gi] = per_wr && (addr_q == TMR_ADDR[gi]);
         cpar_timer #(.W(8)) u_tmr (
            .mclk    (mclk),
            .srst    (srst),
            .clr     (halted_q),
            .load_wr (tmr_wr[gi]),
            .wdata   (wr_val_q),
            .count   (tmr_cnt[gi])
         );
      end
   endgenerate

   assign p1_if.wdata  = wr_val_q;
   assign p1_if.lat_wr = per_wr && (addr_q == `CPAR_A_PORT1);
   assign p1_if.dir_wr = per_wr && (addr_q == `CPAR_A_PORT1_DIR);
   assign p1_if.clr    = halted_q;
   assign pa_if.wdata  = wr_val_q;
   assign pa_if.lat_wr = per_wr && (addr_q == `CPAR_A_PORTA);
   assign pa_if.dir_wr = 1'b0;
   assign pa_if.clr    = halted_q;

   cpar_port #(.HV(1'b0)) u_port1 (
      .mclk    (mclk),
      .srst    (srst),
      .bus     (p1_if.port),
      .pin_in  (port1_pin_in),
      .pin_out (port1_pin_out),
      .pin_oe  (port1_pin_oe)
   );

   cpar_port #(.HV(1'b1)) u_porta (
      .mclk    (mclk),
      .srst    (srst),
      .bus     (pa_if.port),
      .pin_in  (porta_pin_in),
      .pin_out (porta_pin_out),
      .pin_oe  (porta_pin_oe)
   );

   assign avs_readdata    = readdata_q;
   assign avs_waitrequest = wait_q;
   assign irq_ack         = irq_ack_q;
   assign imask           = imask_q;
   assign cpu_halted      = halted_q;
   assign pc              = pc_q;

endmodule

// [cpar_map.svh]
`ifndef CPAR_MAP_SVH
`define CPAR_MAP_SVH

// avalon register byte offsets
`define CPAR_REG_CMD        5'h00
`define CPAR_REG_DATA       5'h04
`define CPAR_REG_RESULT     5'h08
`define CPAR_REG_STATUS     5'h0c
`define CPAR_REG_PC         5'h10
`define CPAR_REG_CCR        5'h14

// command register fields
`define CPAR_CMD_OP_LSB     0
`define CPAR_CMD_BIT_LSB    4
`define CPAR_CMD_CARRY      7
`define CPAR_CMD_ADDR_LSB   16

// status register fields
`define CPAR_ST_HALTED      0
`define CPAR_ST_UNMAPPED    1
`define CPAR_ST_SUBMODE     2
`define CPAR_ST_IMASK       3

// peripheral address map
`define CPAR_A_TIMER_B      16'hffc3
`define CPAR_A_TIMER_C      16'hffc5
`define CPAR_A_TIMER_E      16'hffc9
`define CPAR_A_TMODE_D      16'hffc6
`define CPAR_A_PORT1        16'hffd1
`define CPAR_A_PORTA        16'hffda
`define CPAR_A_PORT1_DIR    16'hffe1
`define CPAR_A_SYSCTL2      16'hfff1
`define CPAR_A_VEC_HI       16'h0000
`define CPAR_A_VEC_LO       16'h0001

// write-only bit masks and field positions
`define CPAR_CRL_BIT        7
`define CPAR_DIRECT_TRANSFER_ON_BIT       3
`define CPAR_TMODE_WO_MASK  8'h80
`define CPAR_SYSCTL2_WO_MASK 8'h08
`define CPAR_DIR_WO_MASK    8'hff

// reset values and fill pattern
`define CPAR_TMODE_RST      8'h00
`define CPAR_SYSCTL2_RST    8'h00
`define CPAR_UNDEF_BYTE     8'h00

`endif

// [cpar_pkg.sv]
package cpar_pkg;

   typedef enum logic [3:0] {
      OP_RDB = 4'h0,
      OP_WRB = 4'h1,
      OP_RDW = 4'h2,
      OP_WRW = 4'h3,
      OP_SET = 4'h4,
      OP_CLR = 4'h5,
      OP_NOT = 4'h6,
      OP_ST  = 4'h7,
      OP_IST = 4'h8
   } cpar_op_t;

   typedef enum logic [3:0] {
      S_RESET = 4'h0,
      S_VEC   = 4'h1,
      S_FETCH = 4'h2,
      S_IDLE  = 4'h3,
      S_RD_A  = 4'h4,
      S_RD_B  = 4'h5,
      S_MOD   = 4'h6,
      S_WR_A  = 4'h7,
      S_WR_B  = 4'h8,
      S_DONE  = 4'h9
   } cpar_state_t;

endpackage

// [cpar_pbus_if.sv]
`timescale 1ns/100ps
interface cpar_pbus_if;
   logic [7:0] wdata;
   logic       lat_wr;
   logic       dir_wr;
   logic       clr;
   logic [7:0] rdata;

   modport cpu  (output wdata, output lat_wr, output dir_wr, output clr,
                 input rdata);
   modport port (input wdata, input lat_wr, input dir_wr, input clr,
                 output rdata);
endinterface

// [cpar_timer.sv]
`timescale 1ns/100ps
module cpar_timer #(
   parameter int W = 8
) (
   // clock and reset
   input  logic         mclk,
   input  logic         srst,
   input  logic         clr,
   // shared-address access
   input  logic         load_wr,
   input  logic [W-1:0] wdata,
   output logic [W-1:0] count
);

   logic [W-1:0] reload_q;
   logic [W-1:0] count_q;

   always_ff @(posedge mclk) begin
      if (srst || clr) begin
         reload_q <= '0;
      end else if (load_wr) begin
         reload_q <= wdata;
      end
   end

   // counting never pauses for a bus access
   always_ff @(posedge mclk) begin
      if (srst || clr) begin
         count_q <= '0;
      end else if (&count_q) begin
         count_q <= reload_q;
      end else begin
         count_q <= count_q + 1'b1;
      end
   end

   assign count = count_q;

endmodule

// [cpar_port.sv]
`timescale 1ns/100ps
module cpar_port #(
   parameter bit HV = 1'b0
) (
   // clock and reset
   input  logic       mclk,
   input  logic       srst,
   // register side
   cpar_pbus_if.port  bus,
   // pins
   input  logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe
);

   logic [7:0] s1_q;
   logic [7:0] s2_q;
   logic [7:0] lat_q;
   logic [7:0] dir_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || bus.clr) begin
         lat_q <= 8'h00;
      end else if (bus.lat_wr) begin
         lat_q <= bus.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || bus.clr) begin
         dir_q <= 8'h00;
      end else if (bus.dir_wr && !HV) begin
         dir_q <= bus.wdata;
      end
   end

   assign pin_out = lat_q;

   generate
      if (HV) begin : g_hv
         // pull-up only: latch 1 drives high, latch 0 lets the pin float
         assign pin_oe    = lat_q;
         assign bus.rdata = s2_q;
      end else begin : g_std
         assign pin_oe    = dir_q;
         assign bus.rdata = (dir_q & lat_q) | (~dir_q & s2_q);
      end
   endgenerate

endmodule

// [cpar_pins.sv]
`timescale 1ns/100ps
// pin-side load: driven bits read back, floating bits take ext
module cpar_pins (
   // pad side
   input  logic [7:0] out,
   input  logic [7:0] oe,
   input  logic [7:0] ext,
   input  logic [7:0] low,
   // sampled level
   output logic [7:0] pin
);
   // a heavy load drags a driven-high pin below input low
   assign pin = (oe & out & ~low) | (~oe & ext);
endmodule

// [cpar_monitor.sv]
`timescale 1ns/100ps
module cpar_monitor #(
   parameter logic [15:0] RESET_VECTOR = 16'h0100
) (
   // clock and reset
   input logic        mclk,
   input logic        srst,
   // watched outputs, plus the irq_req input
   input logic        avs_waitrequest,
   input logic        irq_req,
   input logic        irq_ack,
   input logic        imask,
   input logic        cpu_halted,
   input logic [15:0] pc,
   input logic [7:0]  port1_pin_oe,
   input logic [7:0]  porta_pin_out,
   input logic [7:0]  porta_pin_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_boot;
      $fell(cpu_halted);
   endsequence
   sequence s_held;
      cpu_halted ##1 cpu_halted;
   endsequence
   a_wait_one: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_vector_load: assert property (
      s_boot |-> ##[3:4] pc == RESET_VECTOR)
      else $error("pc not loaded with vector");
   a_halt_mask: assert property (
      s_held |-> imask)
      else $error("mask clear in reset");
   a_halt_pins: assert property (
      s_held |-> !port1_pin_oe && !porta_pin_oe)
      else $error("pins driven in reset");
   a_ack_cause: assert property (
      irq_ack |-> $past(irq_req) && !$past(imask))
      else $error("ack without unmasked request");
   a_ack_masks: assert property (
      irq_ack |=> imask && !irq_ack)
      else $error("ack not masking");
   a_reset_first: assert property (
      cpu_halted |-> !irq_ack)
      else $error("ack during reset");
   a_hv_drive: assert property (
      porta_pin_oe == porta_pin_out)
      else $error("hv enable differs from latch");
endmodule
bind cpar_top cpar_monitor #(.RESET_VECTOR(RESET_VECTOR)) u_mon (
   .mclk(mclk), .srst(srst), .avs_waitrequest(avs_waitrequest),
   .irq_req(irq_req), .irq_ack(irq_ack), .imask(imask),
   .cpu_halted(cpu_halted), .pc(pc), .port1_pin_oe(port1_pin_oe),
   .porta_pin_out(porta_pin_out), .porta_pin_oe(porta_pin_oe));

// [cpar_top_bench.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
 $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module cpar_top_bench;
   logic        mclk = 0, srst = 1, rd_q = 0, wr_q = 0, rst_n = 0, irq = 0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wd = 32'h0, rdat, we, wm;
   logic        wait_q, ack, imask, halted;
   logic        sm = 0;
   logic [15:0] pc;
   logic [7:0]  p1i, p1o, p1e, pai, pao, pae, v, r, m8;
   logic [7:0]  p1x = 8'h00, pax = 8'h00, palow = 8'h00;
   logic [31:0] qe[$], qm[$];
   int          n_fail = 0, cmp_count = 0, i, o;
   always #20 mclk = ~mclk;
   cpar_top dut (.mclk(mclk), .srst(srst), .avs_address(adr),
      .avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wd),
      .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wait_q),
      .reset_n_input(rst_n), .sub_mode(sm), .irq_req(irq), .irq_ack(ack),
      .imask(imask), .cpu_halted(halted), .pc(pc), .port1_pin_in(p1i),
      .port1_pin_out(p1o), .port1_pin_oe(p1e), .porta_pin_in(pai),
      .porta_pin_out(pao), .porta_pin_oe(pae));
   cpar_pins u_p1 (.out(p1o), .oe(p1e), .ext(p1x), .low(8'h00), .pin(p1i));
   cpar_pins u_pa (.out(pao), .oe(pae), .ext(pax), .low(palow), .pin(pai));
   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) if (rd_q && wait_q === 1'b0) begin
      we = qe.pop_front();
      wm = qm.pop_front();
      `CHK(rdat & wm, we)
   end
   task end_of_test;
      $display("checks %0d fails %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // held until waitrequest is seen low; watchdog bounds the wait
   task bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      adr <= a; wr_q <= w; rd_q <= !w; wd <= d;
      @(posedge mclk);
      while (wait_q !== 1'b0) @(posedge mclk);
      rd_q <= 0; wr_q <= 0;
      @(posedge mclk);
   endtask
   task rd(input logic [4:0] a, input logic [31:0] e, m);
      qe.push_back(e); qm.push_back(m); bus(a, 1'b0, 32'h0);
   endtask
   // carry for store ops rides on data bit 15
   task x(input logic [3:0] op, input logic [2:0] b, input logic [15:0] a,
          d, input logic [31:0] e, m);
      bus(5'h04, 1'b1, {16'h0, d});
      bus(5'h00, 1'b1, {a, 8'h00, d[15], b, op});
      rd(5'h08, e, m);
   endtask
   task boot;
      i = 0;
      while (halted !== 1'b0 && i < 100) begin @(posedge mclk); i++; end
      repeat (6) @(posedge mclk);
      `CHK(pc, 16'h0100)
   endtask
   initial begin #800000; n_fail++; end_of_test; end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'he6d0));
      repeat (16) @(posedge mclk);
      srst <= 0; rst_n <= 1;
      boot;
      rd(5'h0c, 32'h8, 32'hf);
      x(1, 0, 16'h8000, 16'h00ff, 0, 0);
      x(0, 0, 16'h8000, 0, 0, 32'hffff);
      rd(5'h0c, 32'ha, 32'hf);
      bus(5'h0c, 1'b1, 32'h2);
      rd(5'h18, 0, 32'hffffffff);
      x(2, 0, 16'h0000, 0, 32'h0100, 32'hffff);
      r = $urandom; p1x <= r;
      x(1, 0, 16'hffe1, 16'h000f, 0, 0);
      x(3, 0, 16'hffd1, 16'h5aa5, 0, 0);
      `CHK(p1o, 8'h5a)
      x(2, 0, 16'hffd1, 0, {r[7:4], 12'ha00}, 32'hffff);
      x(5, 1, 16'hffd1, 0, 0, 0);
      `CHK(p1o, {r[7:4], 4'h8})
      // an undefined op code must leave the port latch alone
      x(15, 1, 16'hffd1, 0, 0, 0);
      `CHK(p1o, {r[7:4], 4'h8})
      x(5, 7, 16'hffe1, 0, 0, 0);
      `CHK(p1e, 8'h7f)
      pax <= 8'h0f;
      x(4, 7, 16'hffda, 0, 0, 0);
      `CHK(pao, 8'h8f)
      palow <= 8'h01;
      x(6, 6, 16'hffda, 0, 0, 0);
      `CHK(pao, 8'hce)
      x(0, 0, 16'hffc3, 0, 0, 0);
      v = rdat[7:0];
      x(0, 0, 16'hffc3, 0, 0, 0);
      `CHK(rdat[7:0] !== v, 1'b1)
      v = 8'h00;
      for (o = 4; o < 9; o++) begin
         r = $urandom; m8 = 8'h01 << r[2:0]; v = v | 8'h80;
         case (o)
            4: v = v | m8;
            5: v = v & ~m8;
            6: v = v ^ m8;
            7: v = r[3] ? v | m8 : v & ~m8;
            default: v = r[3] ? v & ~m8 : v | m8;
         endcase
         x(o[3:0], r[2:0], 16'hffc6, {r[3], 15'h0}, 0, 0);
         x(0, 0, 16'hffc6, 0, {24'h0, v | 8'h80}, 32'hffff);
      end
      x(0, 0, 16'hfff1, 0, 32'h08, 32'hffff);
      // subclock mode: the control byte takes writes, transfer bit reads 1
      sm <= 1;
      x(1, 0, 16'hfff1, 16'h0070, 0, 0);
      x(0, 0, 16'hfff1, 0, 32'h78, 32'hffff);
      rd(5'h0c, 32'h4, 32'h4);
      // unmask only after boot, once software would have set its stack
      bus(5'h14, 1'b1, 32'h0);
      irq <= 1;
      i = 0;
      while (ack !== 1'b1 && i < 20) begin @(posedge mclk); i++; end
      `CHK(ack, 1'b1)
      irq <= 0;
      @(posedge mclk);
      `CHK(imask, 1'b1)
      rst_n <= 0;
      repeat (10) @(posedge mclk);
      `CHK(halted, 1'b1)
      `CHK(pae, 8'h00)
      `CHK(pc, 16'h0000)
      rst_n <= 1;
      boot;
      end_of_test;
   end
endmodule
